// ==== hdl/nv_host_ctrl.sv ====
// Operation
// - a store is started by six reads at 0000,1555,0aaa,1fff,10f0,0f0f in order, the last reading no data.
// - a recall uses the same five reads and ends at 0f0e instead.
// - write enable is held high through all six sequence reads.
// - on a read write enable stays high for the whole cycle.
// - a write happens with select and write enable low, address held until either rises.
`timescale 1ns/100ps
`default_nettype none
module nv_host_ctrl
   import nv_host_pkg::*;
#(
   parameter int STORE_CYC = STORE_CYC_DEF,
   parameter int RECALL_CYC = RECALL_CYC_DEF
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic req_valid_in,
   input wire logic [1:0] req_cmd_in,
   input wire logic [12:0] req_addr_in,
   input wire logic [7:0] req_wdata_in,
   input wire logic hw_store_in,
   output logic req_ready_out,
   output logic rsp_valid_out,
   output logic [7:0] rsp_rdata_out,
   output logic chip_sel_n_out,
   output logic write_en_n_out,
   output logic out_en_n_out,
   output logic [12:0] byte_address_out,
   output logic [7:0] data_bus_out,
   output logic data_bus_oe_out,
   input wire logic [7:0] data_bus_in,
   output logic store_busy_n_out,
   output logic store_busy_oe_out,
   input wire logic store_busy_n_in
);
   typedef enum logic [3:0] {
      S_IDLE, S_SETUP, S_PULSE, S_HOLD, S_NV_WAIT, S_HW_ASSERT, S_HW_WAIT
   } state_t;

   localparam int CNT_W = $clog2(STORE_CYC + 2);
   localparam logic [CNT_W-1:0] CNT_SETUP = CNT_W'(SETUP_CYC);
   localparam logic [CNT_W-1:0] CNT_PULSE = CNT_W'(PULSE_CYC);
   localparam logic [CNT_W-1:0] CNT_HOLD = CNT_W'(HOLD_CYC);
   localparam logic [CNT_W-1:0] CNT_STORE = CNT_W'(STORE_CYC);
   localparam logic [CNT_W-1:0] CNT_RECALL = CNT_W'(RECALL_CYC);
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
   localparam logic [2:0] SEQ_LAST = 3'(SEQ_LEN - 1);

   state_t state_q;
   logic [CNT_W-1:0] cnt_q;
   logic [1:0] cmd_q;
   logic [12:0] addr_q;
   logic [7:0] wdata_q;
   logic [2:0] seq_idx_q;
   logic [2:0] seq_idx_d;
   logic [12:0] seq_addr;
   logic hsb_s1_q;
   logic hsb_s2_q;
   logic is_seq;
   logic cnt_done;

   assign is_seq = (cmd_q == CMD_STORE) || (cmd_q == CMD_RECALL);
   assign cnt_done = (cnt_q == CNT_ONE);
   assign req_ready_out = (state_q == S_IDLE) && !hw_store_in && hsb_s2_q;

   // the rom output is registered, so it is fed the index of the next
   // cycle; its address then stands while the setup cycle loads the pins
   always_comb begin
      seq_idx_d = seq_idx_q;
      if (state_q == S_IDLE) begin
         seq_idx_d = 3'h0;
      end else if (state_q == S_HOLD && cnt_done && is_seq
                   && seq_idx_q != SEQ_LAST) begin
         seq_idx_d = seq_idx_q + 3'h1;
      end
   end

   seq_addr_rom u_rom (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .index_in(seq_idx_d),
      .recall_in(cmd_q == CMD_RECALL),
      .addr_out(seq_addr)
   );

   // store_busy_n is a pin shared with other devices
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         hsb_s1_q <= 1'b1;
         hsb_s2_q <= 1'b1;
      end else begin
         hsb_s1_q <= store_busy_n_in;
         hsb_s2_q <= hsb_s1_q;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_q <= S_IDLE;
         cnt_q <= '0;
         cmd_q <= CMD_READ;
         addr_q <= 13'h0000;
         wdata_q <= 8'h00;
         seq_idx_q <= 3'h0;
      end else begin
         case (state_q)
            S_IDLE: begin
               seq_idx_q <= 3'h0;
               if (hw_store_in && hsb_s2_q) begin
                  state_q <= S_HW_ASSERT;
                  cnt_q <= CNT_PULSE;
               end else if (req_ready_out && req_valid_in) begin
                  cmd_q <= req_cmd_in;
                  addr_q <= req_addr_in;
                  wdata_q <= req_wdata_in;
                  cnt_q <= CNT_SETUP;
                  state_q <= S_SETUP;
               end
            end
            S_SETUP: begin
               if (cnt_done) begin
                  cnt_q <= CNT_PULSE;
                  state_q <= S_PULSE;
               end else begin
                  cnt_q <= cnt_q - CNT_ONE;
               end
            end
            S_PULSE: begin
               if (cnt_done) begin
                  cnt_q <= CNT_HOLD;
                  state_q <= S_HOLD;
               end else begin
                  cnt_q <= cnt_q - CNT_ONE;
               end
            end
            S_HOLD: begin
               if (!cnt_done) begin
                  cnt_q <= cnt_q - CNT_ONE;
               end else if (is_seq && seq_idx_q != SEQ_LAST) begin
                  // back to back reads, nothing may intervene
                  seq_idx_q <= seq_idx_q + 3'h1;
                  cnt_q <= CNT_SETUP;
                  state_q <= S_SETUP;
               end else if (is_seq) begin
                  cnt_q <= (cmd_q == CMD_STORE) ? CNT_STORE : CNT_RECALL;
                  state_q <= S_NV_WAIT;
               end else begin
                  state_q <= S_IDLE;
               end
            end
            S_NV_WAIT: begin
               if (cnt_done) begin
                  state_q <= S_IDLE;
               end else begin
                  cnt_q <= cnt_q - CNT_ONE;
               end
            end
            S_HW_ASSERT: begin
               if (cnt_done) begin
                  state_q <= S_HW_WAIT;
               end else begin
                  cnt_q <= cnt_q - CNT_ONE;
               end
            end
            S_HW_WAIT: begin
               if (hsb_s2_q) begin
                  state_q <= S_IDLE;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // bus pins; write enable never falls before select so data stay off
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         chip_sel_n_out <= 1'b1;
         write_en_n_out <= 1'b1;
         out_en_n_out <= 1'b1;
         byte_address_out <= 13'h0000;
         data_bus_out <= 8'h00;
         data_bus_oe_out <= 1'b0;
      end else begin
         chip_sel_n_out <= !(state_q == S_PULSE);
         write_en_n_out <= !(state_q == S_PULSE && cmd_q == CMD_WRITE);
         // sequence reads need no data; oe left high on all six
         out_en_n_out <= !(state_q == S_PULSE && cmd_q == CMD_READ);
         if (state_q == S_SETUP) begin
            byte_address_out <= is_seq ? seq_addr : addr_q;
         end
         data_bus_out <= wdata_q;
         // data held one cycle past the strobe so the capture never races
         data_bus_oe_out <= cmd_q == CMD_WRITE && (state_q == S_SETUP
            || state_q == S_PULSE || state_q == S_HOLD);
      end
   end

   // open-drain store request, released after the pulse; wait on pin high
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         store_busy_n_out <= 1'b1;
         store_busy_oe_out <= 1'b0;
         rsp_valid_out <= 1'b0;
         rsp_rdata_out <= 8'h00;
      end else begin
         store_busy_n_out <= 1'b0;
         store_busy_oe_out <= (state_q == S_HW_ASSERT);
         rsp_valid_out <= (state_q == S_HOLD) && cnt_done
                          && !(is_seq && seq_idx_q != SEQ_LAST)
                          && !(is_seq && cmd_q == CMD_READ);
         if (state_q == S_PULSE && cnt_done && cmd_q == CMD_READ) begin
            rsp_rdata_out <= data_bus_in;
         end
      end
   end
endmodule // nv_host_ctrl
`default_nettype wire

// ==== hdl/seq_addr_rom.sv ====
`timescale 1ns/100ps
`default_nettype none
module seq_addr_rom
   import nv_host_pkg::*;
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [2:0] index_in,
   input wire logic recall_in,
   output logic [12:0] addr_out
);
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         addr_out <= 13'h0000;
      end else begin
         case (index_in)
            3'h0: addr_out <= SEQ_A0;
            3'h1: addr_out <= SEQ_A1;
            3'h2: addr_out <= SEQ_A2;
            3'h3: addr_out <= SEQ_A3;
            3'h4: addr_out <= SEQ_A4;
            default: addr_out <= recall_in ? SEQ_RECALL : SEQ_STORE;
         endcase
      end
   end
endmodule // seq_addr_rom
`default_nettype wire

// ==== shared/nv_host_pkg.sv ====
package nv_host_pkg;
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam int SEQ_LEN = 6;
   localparam logic [12:0] SEQ_A0 = 13'h0000;
   localparam logic [12:0] SEQ_A1 = 13'h1555;
   localparam logic [12:0] SEQ_A2 = 13'h0aaa;
   localparam logic [12:0] SEQ_A3 = 13'h1fff;
   localparam logic [12:0] SEQ_A4 = 13'h10f0;
   localparam logic [12:0] SEQ_STORE = 13'h0f0f;
   localparam logic [12:0] SEQ_RECALL = 13'h0f0e;
   // bus phase timing in ns at a 10 ns clock
   localparam int CLK_NS = 10;
   localparam int SETUP_NS = 10;
   localparam int PULSE_NS = 50;
   localparam int HOLD_NS = 10;
   localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
   // store takes up to 10 ms, recall up to 20 us
   localparam int STORE_US = 10000;
   localparam int RECALL_US = 20;
   localparam int STORE_CYC_DEF = STORE_US * 1000 / CLK_NS;
   localparam int RECALL_CYC_DEF = RECALL_US * 1000 / CLK_NS;
   localparam logic [1:0] CMD_READ = 2'h0;
   localparam logic [1:0] CMD_WRITE = 2'h1;
   localparam logic [1:0] CMD_STORE = 2'h2;
   localparam logic [1:0] CMD_RECALL = 2'h3;
endpackage

// ==== sim/nv_device_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module nv_device_model
   import nv_host_pkg::*;
(
   input wire logic cs_n_in,
   input wire logic we_n_in,
   input wire logic oe_n_in,
   input wire logic [12:0] addr_in,
   input wire logic [7:0] dq_in,
   input wire logic hsb_n_in,
   output logic [7:0] dq_out,
   output logic dq_oe_out,
   output logic pull_out,
   output var int stores_out,
   output var int recalls_out
);
   logic [7:0] mem [8192];
   logic [12:0] seq [5] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
   int step = 0;
   logic dirty = 0;
   logic busy = 0;
   logic last_step;
   logic wr;
   initial begin
      pull_out = 0;
      stores_out = 0;
      recalls_out = 0;
   end
   assign last_step = step == 5 && (addr_in == SEQ_STORE ||
      addr_in == SEQ_RECALL);
   // inhibited while busy or pin low; last sequence step floats the bus
   assign dq_oe_out = !cs_n_in && !oe_n_in && we_n_in && hsb_n_in &&
      !busy && !last_step;
   assign dq_out = mem[addr_in];
   assign wr = !cs_n_in && !we_n_in && hsb_n_in && !busy;
   always @(negedge wr) begin
      mem[addr_in] = dq_in;
      dirty = 1;
      step = 0;
   end
   always @(posedge cs_n_in) begin
      if (we_n_in && hsb_n_in && !busy) begin
         if (last_step) begin
            if (addr_in == SEQ_STORE) stores_out++;
            else recalls_out++;
            // a recall is no write, so it leaves the flag alone
            if (addr_in == SEQ_STORE) dirty = 0;
            step = 0;
            busy = 1;
            // deselect does not end the cycle early
            #80 busy = 0;
         end else if (addr_in == seq[step]) step++;
         else step = int'(addr_in == SEQ_A0);
      end
   end
   always @(negedge hsb_n_in) begin
      if (dirty) begin
         stores_out++;
         dirty = 0;
         pull_out = 1;
         #200 pull_out = 0;
      end
   end
endmodule // nv_device_model
`default_nettype wire

// ==== sim/nv_host_ctrl_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module nv_host_ctrl_properties
   import nv_host_pkg::*;
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic req_valid_in,
   input wire logic [1:0] req_cmd_in,
   input wire logic hw_store_in,
   input wire logic req_ready_out,
   input wire logic rsp_valid_out,
   input wire logic chip_sel_n_out,
   input wire logic write_en_n_out,
   input wire logic out_en_n_out,
   input wire logic [12:0] byte_address_out,
   input wire logic data_bus_oe_out,
   input wire logic store_busy_n_out,
   input wire logic store_busy_oe_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   a_addr_held: assert property (!chip_sel_n_out && $past(!chip_sel_n_out)
      |-> $stable(byte_address_out)) else $error("address moved");
   a_we_with_sel: assert property (!write_en_n_out |-> !chip_sel_n_out)
      else $error("write strobe unselected");
   a_we_steady: assert property (!chip_sel_n_out && $past(!chip_sel_n_out)
      |-> $stable(write_en_n_out)) else $error("strobe moved");
   a_no_contention: assert property (!out_en_n_out |-> write_en_n_out &&
      !data_bus_oe_out) else $error("bus contention");
   a_pulse_len: assert property ($fell(chip_sel_n_out) |->
      !chip_sel_n_out [*5] ##1 chip_sel_n_out) else $error("strobe");
   a_read_answer: assert property (req_valid_in && req_ready_out &&
      req_cmd_in == CMD_READ |-> ##8 rsp_valid_out) else $error("late");
   a_hw_refuse: assert property (hw_store_in |-> !req_ready_out)
      else $error("ready during pin store");
   a_pin_quiet: assert property (store_busy_oe_out |-> chip_sel_n_out &&
      !store_busy_n_out) else $error("bus active in pin store");
   a_pin_pulse: assert property ($rose(store_busy_oe_out) |->
      store_busy_oe_out [*5] ##1 !store_busy_oe_out) else $error("pin");
   c_write: cover property ($fell(write_en_n_out));
   c_pin: cover property ($rose(store_busy_oe_out));
   c_seq: cover property (req_valid_in && req_cmd_in == CMD_STORE);
endmodule // nv_host_ctrl_properties
bind nv_host_ctrl nv_host_ctrl_properties props_i (.clk_in(clk_in),
   .nrst_in(nrst_in), .req_valid_in(req_valid_in), .req_cmd_in(req_cmd_in),
   .hw_store_in(hw_store_in), .req_ready_out(req_ready_out),
   .rsp_valid_out(rsp_valid_out), .chip_sel_n_out(chip_sel_n_out),
   .write_en_n_out(write_en_n_out), .out_en_n_out(out_en_n_out),
   .byte_address_out(byte_address_out), .data_bus_oe_out(data_bus_oe_out),
   .store_busy_n_out(store_busy_n_out),
   .store_busy_oe_out(store_busy_oe_out));
`default_nettype wire

// ==== sim/nv_host_ctrl_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module nv_host_ctrl_test;
   import nv_host_pkg::*;
`define check(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
   $display("wrong value at %0t: mismatch", $time); end end
   logic clk_in = 0, nrst_in = 0, req_valid_in = 0, hw_store_in = 0;
   logic [1:0] req_cmd_in = 0;
   logic [12:0] req_addr_in = 0, byte_address_out;
   logic [7:0] req_wdata_in = 0, rsp_rdata_out, data_bus_out, dev_dq, dq;
   logic req_ready_out, rsp_valid_out, chip_sel_n_out, write_en_n_out;
   logic out_en_n_out, data_bus_oe_out, store_busy_n_out, store_busy_oe_out;
   logic dev_oe, dev_pull, store_busy_n;
   int fails = 0, tests_run = 0, stores, recalls;
   logic [12:0] abort_tbl [7] = '{13'h0000, 13'h1555, 13'h0aaa, 13'h1fff,
      13'h10f0, 13'h0123, 13'h0f0f};
   // undriven bus toggles so a stale value cannot pass for data
   assign dq = data_bus_oe_out ? data_bus_out :
      dev_oe ? dev_dq : {4{clk_in, ~clk_in}};
   assign store_busy_n = !(store_busy_oe_out && !store_busy_n_out) && !dev_pull;
   nv_host_ctrl #(.STORE_CYC(20), .RECALL_CYC(10)) nv_host_ctrl_i (
      .clk_in(clk_in), .nrst_in(nrst_in), .req_valid_in(req_valid_in),
      .req_cmd_in(req_cmd_in), .req_addr_in(req_addr_in),
      .req_wdata_in(req_wdata_in), .hw_store_in(hw_store_in),
      .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
      .rsp_rdata_out(rsp_rdata_out), .chip_sel_n_out(chip_sel_n_out),
      .write_en_n_out(write_en_n_out), .out_en_n_out(out_en_n_out),
      .byte_address_out(byte_address_out), .data_bus_out(data_bus_out),
      .data_bus_oe_out(data_bus_oe_out), .data_bus_in(dq),
      .store_busy_n_out(store_busy_n_out),
      .store_busy_oe_out(store_busy_oe_out), .store_busy_n_in(store_busy_n));
   nv_device_model nv_device_model_i (.cs_n_in(chip_sel_n_out),
      .we_n_in(write_en_n_out), .oe_n_in(out_en_n_out),
      .addr_in(byte_address_out), .dq_in(dq), .hsb_n_in(store_busy_n),
      .dq_out(dev_dq), .dq_oe_out(dev_oe), .pull_out(dev_pull),
      .stores_out(stores), .recalls_out(recalls));
   task automatic idle_wait();
      int n;
      n = 0;
      @(negedge clk_in);
      while (req_ready_out !== 1'b1 && n++ < 4000) @(negedge clk_in);
   endtask
   task automatic op(input logic [1:0] c, input logic [12:0] a,
         input logic [7:0] d);
      int n;
      n = 0;
      idle_wait();
      req_valid_in = 1;
      req_cmd_in = c;
      req_addr_in = a;
      req_wdata_in = d;
      @(negedge clk_in);
      req_valid_in = 0;
      while (rsp_valid_out !== 1'b1 && n++ < 100) @(negedge clk_in);
      `check(rsp_valid_out, 1'b1)
   endtask
   task automatic rd(input logic [12:0] a, input logic [7:0] e);
      op(CMD_READ, a, 8'h00);
      `check(rsp_rdata_out, e)
   endtask
   task automatic pin_store();
      idle_wait();
      hw_store_in = 1;
      @(negedge clk_in);
      hw_store_in = 0;
      `check(req_ready_out, 1'b0)
      repeat (2) @(negedge clk_in);
      idle_wait();
   endtask
   task automatic t_rw();
      op(CMD_WRITE, 13'h1fff, 8'ha5);
      op(CMD_WRITE, 13'h0000, 8'h3c);
      rd(13'h1fff, 8'ha5);
      rd(13'h0000, 8'h3c);
   endtask
   task automatic t_seq();
      op(CMD_STORE, 13'h0000, 8'h00);
      `check(stores, 1)
      op(CMD_RECALL, 13'h0000, 8'h00);
      `check(recalls, 1)
      rd(13'h1fff, 8'ha5);
   endtask
   task automatic t_abort();
      for (int i = 0; i < 7; i++) op(CMD_READ, abort_tbl[i], 8'h00);
      `check(stores, 1)
   endtask
   task automatic t_pin();
      pin_store();
      `check(stores, 1)
      op(CMD_WRITE, 13'h0100, 8'h77);
      pin_store();
      `check(stores, 2)
      rd(13'h0100, 8'h77);
   endtask
   task automatic results();
      if (fails == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial forever #5 clk_in = ~clk_in;
   initial begin
      #200000;
      fails++;
      results();
   end
   initial begin
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      nrst_in = 1;
      t_rw();
      t_seq();
      t_abort();
      t_pin();
      results();
   end
endmodule // nv_host_ctrl_test
`default_nettype wire
